// file: odac_map.vh
// Constants for the octal DAC serial input block
`ifndef ODAC_MAP_VH
`define ODAC_MAP_VH
`define ODAC_WORD_BITS 16
`define ODAC_CNT_W 5
`define ODAC_CHANNELS 8
`define ODAC_DATA_W 12
// Word layout: bit 15 selects control, bits 14:12 address, 11:0 data
`define ODAC_CTRL_BIT 15
`define ODAC_ADDR_HI 14
`define ODAC_ADDR_LO 12
// Control word fields: group EFGH bits 3:2, group ABCD bits 1:0
`define ODAC_BUF_ABCD 0
`define ODAC_SUP_ABCD 1
`define ODAC_BUF_EFGH 2
`define ODAC_SUP_EFGH 3
// Reference source codes
`define ODAC_REF_UNBUF 2'h0
`define ODAC_REF_BUF 2'h1
`define ODAC_REF_SUPPLY 2'h2
// Fastest serial clock the host may use, in kHz
`define ODAC_SCLK_MAX_KHZ 30000
`endif

// file: odac_sync2.v
// Two-flop synchroniser for one pin
`default_nettype none
module odac_sync2 (
    input wire mclk,
    input wire nrst,
    input wire pinIn,
    output reg pinSync
);
    reg stage1;

    // First stage feeds only the second
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= 1'b0;
            pinSync <= 1'b0;
        end else begin
            stage1 <= pinIn;
            pinSync <= stage1;
        end
    end
endmodule
`default_nettype wire

// file: odac_serial_input.v
// Serial write port and load control of an octal voltage DAC
//
// Behaviour
// R1 - Frame strobe falling arms clock and data inputs and the shift register.
// R2 - One bit per falling serial clock edge, sixteen bits per frame.
// R3 - Strobe rising before sixteenth edge aborts; nothing changes.
// R4 - After a complete word, clock and data are ignored until next frame.
// R5 - Load strobe low copies input registers into DAC registers.
// R6 - Load pulse updates all pending channels together.
// R7 - Host may hold load strobe low for pass-through updates.
// R8 - Each four-channel group picks buffered, unbuffered or supply reference.
// R9 - Host keeps serial clock at or below 30 MHz.
// R10 - Sixteenth edge decodes word into input register or control.
`default_nettype none
`include "odac_map.vh"
module odac_serial_input #(
    parameter DATA_W = `ODAC_DATA_W
) (
    input wire mclk,
    input wire nrst,
    input wire frameSync_n,
    input wire serialClk,
    input wire serialData,
    input wire load_strobe_n,
    output reg [8*DATA_W-1:0] dacCode,
    output reg [1:0] refSelAbcd,
    output reg [1:0] refSelEfgh,
    output reg wordDone,
    output reg frameAbort
);
    // One-hot frame states
    localparam ST_IDLE = 2'b01;
    localparam ST_SHIFT = 2'b10;
    // Bit counter value at the last bit of a word, and its step
    localparam [`ODAC_CNT_W-1:0] LAST_BIT = `ODAC_WORD_BITS - 1;
    localparam [`ODAC_CNT_W-1:0] CNT_STEP = 1;

    // Synchronised pin levels
    wire syncS;
    wire clkS;
    wire dinS;
    wire ldS;
    // Edge history and detected edges of the synchronised pins
    reg clkPrev;
    reg syncPrev;
    wire clkFall;
    wire syncFall;
    wire syncRise;
    // Frame sequencing and the shift register
    reg [1:0] state;
    reg [`ODAC_CNT_W-1:0] bitCnt;
    reg [`ODAC_WORD_BITS-1:0] shiftReg;
    reg wordStrobe;
    wire lastBit;
    wire [`ODAC_WORD_BITS-1:0] fullWord;
    // Fields of the captured word
    wire isCtrl;
    wire [2:0] wordAddr;
    wire [7:0] chanSel;
    // Stored words: input registers, new-data flags, control bits
    reg [8*DATA_W-1:0] inputReg;
    reg [7:0] pending;
    reg [3:0] ctrlBits;

    // Reference source from buffer bit and supply bit
    function [1:0] refSel;
        input bufBit;
        input supBit;
        begin
            if (supBit) begin
                refSel = `ODAC_REF_SUPPLY;
            end else if (bufBit) begin
                refSel = `ODAC_REF_BUF;
            end else begin
                refSel = `ODAC_REF_UNBUF;
            end
        end
    endfunction

    // One-hot channel select from a word's address field
    function [7:0] chanOneHot;
        input [2:0] addr;
        begin
            chanOneHot = 8'h01 << addr;
        end
    endfunction

    odac_sync2 uSync (.mclk(mclk), .nrst(nrst), .pinIn(frameSync_n),
        .pinSync(syncS));
    odac_sync2 uClk (.mclk(mclk), .nrst(nrst), .pinIn(serialClk),
        .pinSync(clkS));
    odac_sync2 uDin (.mclk(mclk), .nrst(nrst), .pinIn(serialData),
        .pinSync(dinS));
    odac_sync2 uLd (.mclk(mclk), .nrst(nrst), .pinIn(load_strobe_n),
        .pinSync(ldS));

    // Falling edges shift and open frames; a rising strobe ends one
    assign clkFall = clkPrev & ~clkS;
    assign syncFall = syncPrev & ~syncS;
    assign syncRise = ~syncPrev & syncS;
    // Next shift value, last-bit test and fields of the held word
    assign fullWord = {shiftReg[`ODAC_WORD_BITS-2:0], dinS};
    assign lastBit = (bitCnt == LAST_BIT);
    assign isCtrl = shiftReg[`ODAC_CTRL_BIT];
    assign wordAddr = shiftReg[`ODAC_ADDR_HI:`ODAC_ADDR_LO];
    assign chanSel = chanOneHot(wordAddr);

    // Edge history; reset levels equal the synchronisers' reset levels,
    // so a pin idling high shows a rise, never a false fall, after reset
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            clkPrev <= 1'b0;
            syncPrev <= 1'b0;
        end else begin
            clkPrev <= clkS;
            syncPrev <= syncS;
        end
    end

    // Frame state machine and shift register
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            bitCnt <= {`ODAC_CNT_W{1'b0}};
            shiftReg <= 16'h0000;
            wordStrobe <= 1'b0;
            frameAbort <= 1'b0;
        end else begin
            wordStrobe <= 1'b0;
            frameAbort <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (syncFall) begin
                        state <= ST_SHIFT; // [R1]
                        bitCnt <= {`ODAC_CNT_W{1'b0}};
                    end
                end
                ST_SHIFT: begin
                    if (syncRise) begin
                        state <= ST_IDLE; // [R3]
                        frameAbort <= 1'b1;
                    end else if (clkFall) begin
                        shiftReg <= fullWord; // [R2]
                        if (lastBit) begin
                            wordStrobe <= 1'b1; // [R10]
                            state <= ST_IDLE; // [R4]
                        end else begin
                            bitCnt <= bitCnt + CNT_STEP;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Word decode into input registers and control bits
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            inputReg <= {8*DATA_W{1'b0}};
            ctrlBits <= 4'h0;
        end else if (wordStrobe) begin
            if (isCtrl) begin
                ctrlBits <= shiftReg[3:0]; // [R10]
            end else begin
                inputReg[wordAddr*DATA_W +: DATA_W] <=
                    shiftReg[DATA_W-1:0]; // [R10]
            end
        end
    end

    // Per channel: new-data flag and DAC register
    genvar ch;
    generate
        for (ch = 0; ch < `ODAC_CHANNELS; ch = ch + 1) begin : gChan
            wire hit;
            assign hit = wordStrobe && !isCtrl && chanSel[ch];
            // Low load strobe copies channels holding new data; held low,
            // each fresh word follows one cycle after its input register.
            // A new word and a load in one cycle keep the flag set, so the
            // fresh code is copied on the next cycle instead of lost.
            always @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    pending[ch] <= 1'b0;
                    dacCode[ch*DATA_W +: DATA_W] <= {DATA_W{1'b0}};
                end else begin
                    if (!ldS && pending[ch]) begin
                        dacCode[ch*DATA_W +: DATA_W] <=
                            inputReg[ch*DATA_W +: DATA_W]; // [R5] [R6] [R7]
                    end
                    if (hit) begin
                        pending[ch] <= 1'b1; // [R6]
                    end else if (!ldS) begin
                        pending[ch] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Reference selection per four-channel group
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            refSelAbcd <= `ODAC_REF_UNBUF;
            refSelEfgh <= `ODAC_REF_UNBUF;
        end else begin
            refSelAbcd <= refSel(ctrlBits[`ODAC_BUF_ABCD],
                ctrlBits[`ODAC_SUP_ABCD]); // [R8]
            refSelEfgh <= refSel(ctrlBits[`ODAC_BUF_EFGH],
                ctrlBits[`ODAC_SUP_EFGH]); // [R8]
        end
    end

    // Word-done pulse; rises with the input register write
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wordDone <= 1'b0;
        end else begin
            wordDone <= wordStrobe; // [R10]
        end
    end
endmodule
`default_nettype wire

// file: odac_serial_input_properties.sv
// Port assertions for the DAC serial input block
`default_nettype none
module odac_serial_input_properties #(parameter DATA_W = 12) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic frameSync_n,
    input wire logic load_strobe_n,
    input wire logic [8*DATA_W-1:0] dacCode,
    input wire logic [1:0] refSelAbcd,
    input wire logic [1:0] refSelEfgh,
    input wire logic wordDone,
    input wire logic frameAbort
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Pulses, reference codes and load holding
    property p_done; wordDone |=> !wordDone; endproperty
    a_done: assert property (p_done) else $error("long done");
    property p_abt; frameAbort |=> !frameAbort; endproperty
    a_abt: assert property (p_abt) else $error("long abort");
    property p_keep; frameAbort |-> !wordDone && $stable(refSelAbcd);
        endproperty
    a_keep: assert property (p_keep) else $error("abort wrote");
    property p_ref; $changed({refSelAbcd, refSelEfgh}) |-> wordDone
        || $past(wordDone); endproperty
    a_ref: assert property (p_ref) else $error("stray ref");
    property p_code; refSelAbcd != 2'h3 && refSelEfgh != 2'h3; endproperty
    a_code: assert property (p_code) else $error("bad ref");
    property p_hold; load_strobe_n [*5] |=> $stable(dacCode); endproperty
    a_hold: assert property (p_hold) else $error("dac moved");
    property p_idle; frameSync_n [*8] |=> !wordDone; endproperty
    a_idle: assert property (p_idle) else $error("idle done");
    property p_frm; wordDone |-> !$past(frameSync_n, 6); endproperty
    a_frm: assert property (p_frm) else $error("done no frame");
endmodule
bind odac_serial_input odac_serial_input_properties #(.DATA_W(DATA_W))
    u_props (.mclk(mclk), .nrst(nrst), .frameSync_n(frameSync_n),
    .load_strobe_n(load_strobe_n), .dacCode(dacCode), .wordDone(wordDone),
    .refSelAbcd(refSelAbcd), .refSelEfgh(refSelEfgh),
    .frameAbort(frameAbort));
`default_nettype wire

// file: odac_host_model.sv
// Host serial port model driving frames into the DAC
`default_nettype none
module odac_host_model (
    output var logic frameSync_n,
    output var logic serialClk,
    output var logic serialData
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam realtime HALF = 62.5; // 8 MHz, under the limit
    // Idle: strobe high, clock parked high
    initial begin
        frameSync_n = 1'b1;
        serialClk = 1'b1;
        serialData = 1'b0;
    end
    // MSB first; under 16 clocks aborts, over 16 adds stray clocks
    task automatic send(input logic [15:0] w, input int n);
        frameSync_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            serialData = (i < 16) ? w[15-i] : ~serialData;
            #HALF serialClk = 1'b0;
            #HALF serialClk = 1'b1;
        end
        serialData = ~serialData; // Data line toggled with no clock edge
        #HALF frameSync_n = 1'b1;
        #200;
    endtask
endmodule
`default_nettype wire

// file: odac_serial_input_tb.sv
// Self-checking bench for the DAC serial input block
`default_nettype none
module odac_serial_input_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, nrst, load_strobe_n, frameSync_n, serialClk, serialData;
    logic [95:0] dacCode;
    logic [1:0] refSelAbcd, refSelEfgh;
    logic wordDone, frameAbort;
    logic [11:0] inReg [8];
    logic [15:0] w;
    int bad_count = 0;
    int checks = 0;
    int doneCnt = 0;
    int abortCnt = 0;
    int expDone = 0;
    int expAbort = 0;
    odac_host_model u_odac_host_model (.frameSync_n(frameSync_n),
        .serialClk(serialClk), .serialData(serialData));
    odac_serial_input u_odac_serial_input (.mclk(mclk), .nrst(nrst),
        .frameSync_n(frameSync_n), .serialClk(serialClk),
        .serialData(serialData), .load_strobe_n(load_strobe_n),
        .dacCode(dacCode), .refSelAbcd(refSelAbcd),
        .refSelEfgh(refSelEfgh), .wordDone(wordDone),
        .frameAbort(frameAbort));
    function automatic logic [95:0] image();
        logic [95:0] v;
        for (int c = 0; c < 8; c++) v[12*c +: 12] = inReg[c];
        return v;
    endfunction
    function automatic logic [1:0] refOf(input logic b, input logic s);
        return s ? 2'h2 : (b ? 2'h1 : 2'h0);
    endfunction
    task automatic chk(input string nm, input logic [95:0] e, g);
        checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    task automatic summarize();
        if (bad_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Tally the design's one-cycle pulses mid-cycle, where they stand
    always @(negedge mclk) begin
        if (wordDone === 1'b1) doneCnt++;
        if (frameAbort === 1'b1) abortCnt++;
    end
    // One frame of n clocks, started just off an mclk edge so no pin
    // moves in the time step of an edge; tallies the pulses due
    task automatic xfer(input logic [15:0] word, input int n);
        @(posedge mclk);
        #0.3;
        u_odac_host_model.send(word, n);
        if (n >= 16) expDone++;
        else expAbort++;
    endtask
    // Random channel code, n serial clocks
    task automatic put(input int c, input int n);
        w = {1'b0, 3'(c), 12'($urandom)};
        xfer(w, n);
        if (n >= 16) inReg[c] = w[11:0];
    endtask
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        #300us;
        bad_count++;
        summarize();
    end
    // Main sequence
    initial begin
        nrst = 1'b0;
        load_strobe_n = 1'b1;
        for (int c = 0; c < 8; c++) inReg[c] = 12'h000;
        void'($urandom(23524));
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        repeat (8) @(posedge mclk);
        for (int c = 0; c < 8; c++) put(c, 16 + 2 * (c % 2));
        chk("dacHeld", 96'h0, dacCode);
        @(posedge mclk) load_strobe_n <= 1'b0;
        repeat (6) @(posedge mclk);
        load_strobe_n <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("dacPulse", image(), dacCode);
        load_strobe_n <= 1'b0;
        for (int k = 0; k < 12; k++) begin
            put(k % 8, (k % 3 == 2) ? 15 - k / 3 : 16);
            chk("dacPass", image(), dacCode);
        end
        for (int k = 0; k < 16; k++) begin
            xfer(16'h8000 | 16'(k), 16);
            chk("refSel", 96'({refOf(k[0], k[1]), refOf(k[2], k[3])}),
                96'({refSelAbcd, refSelEfgh}));
        end
        chk("wordDone", 96'(expDone), 96'(doneCnt));
        chk("frameAbort", 96'(expAbort), 96'(abortCnt));
        summarize();
    end
endmodule
`default_nettype wire
